// file: rtl/pbs_sequencer.sv
// power button sequencer: press handling, power-up order and power indicator
// assumes all inputs are synchronous to the 10 MHz standby clock
`timescale 1ns/100ps
module pbs_sequencer import pbs_pkg::*; #(
    parameter int unsigned LONG_PRESS_CYC = LONG_PRESS_CYC_DEF,
    parameter int unsigned MASK_CYC = MASK_CYC_DEF,
    parameter int unsigned DEBOUNCE_CYC = DEBOUNCE_CYC_DEF
) (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic housekeeping_ok_in,
    input wire logic ac_present_in,
    input wire logic button_in,
    input wire logic host_booting_in,
    input wire logic os_running_in,
    input wire logic os_off_done_in,
    input wire logic clocks_stable_in,
    output logic bulk_enable_out,
    output logic reset_ready_out,
    output logic server_reset_n_out,
    output logic os_shutdown_req_out,
    output logic led_green_out,
    output logic led_amber_out
);

    typedef struct packed {
        pbs_state_t st;
        logic [CNT_W-1:0] mask_cnt;
        logic bulk_en;
        logic ready;
        logic srv_run;
        logic shut_req;
        logic led_green;
        logic led_amber;
    } pbs_seq_t;

    localparam pbs_seq_t SEQ_RST = '{st: ST_STANDBY, default: '0};

    pbs_seq_t q;
    pbs_seq_t d;
    logic rst;
    logic press_start;
    logic short_rel;
    logic long_hit;
    logic held;
    logic early_phase;
    logic go_off;

    // the controller stays in reset until standby housekeeping power settles
    assign rst = srst_in || !housekeeping_ok_in;

    pbs_press_timer #(
        .LONG_PRESS_CYC(LONG_PRESS_CYC),
        .DEBOUNCE_CYC(DEBOUNCE_CYC)
    ) u_press (
        .sys_clk_in(sys_clk_in),
        .srst_in(rst),
        .button_in(button_in),
        .press_start_out(press_start),
        .short_release_out(short_rel),
        .long_hit_out(long_hit),
        .held_out(held)
    );

    // before reset release the host cannot be past its firmware handoff point
    assign early_phase = (q.st == ST_POWER_UP) || (q.st == ST_READY) || host_booting_in;

    // next-state logic; all power-down paths merge through go_off
    always_comb begin
        d = q;
        go_off = 1'b0;
        case (q.st)
            ST_STANDBY: begin
                if (press_start) begin
                    d.bulk_en = 1'b1;
                    d.st = ST_POWER_UP;
                end
            end
            ST_POWER_UP: begin
                if (press_start || long_hit) begin
                    go_off = 1'b1;
                end else if (clocks_stable_in) begin
                    d.ready = 1'b1;
                    d.st = ST_READY;
                end
            end
            ST_READY: begin
                if (press_start || long_hit) begin
                    go_off = 1'b1;
                end else begin
                    d.srv_run = 1'b1;
                    d.st = ST_ON;
                end
            end
            ST_ON: begin
                if (long_hit || (early_phase && press_start)) begin
                    go_off = 1'b1;
                end else if (short_rel && os_running_in && !host_booting_in) begin
                    d.shut_req = 1'b1;
                    d.st = ST_SOFT_OFF;
                end
                // short press with the OS absent or hung falls through unchanged
            end
            ST_SOFT_OFF: begin
                // a long press overrides a shutdown that never finishes
                if (os_off_done_in || long_hit) begin
                    go_off = 1'b1;
                end
            end
            ST_MASK: begin
                // button events are dropped here; a press held past the mask needs a new press
                if (q.mask_cnt == CNT_W'(MASK_CYC - 1)) begin
                    d.st = ST_STANDBY;
                end else begin
                    d.mask_cnt = q.mask_cnt + 1'b1;
                end
            end
            default: begin
                d = SEQ_RST;
            end
        endcase
        if (go_off) begin
            d.bulk_en = 1'b0;
            d.ready = 1'b0;
            d.srv_run = 1'b0;
            d.shut_req = 1'b0;
            d.mask_cnt = '0;
            d.st = ST_MASK;
        end
        // indicator follows the supply enable, dark without mains
        d.led_green = d.bulk_en && ac_present_in;
        d.led_amber = !d.bulk_en && ac_present_in;
    end

    // state register
    always_ff @(posedge sys_clk_in) begin
        if (rst) begin
            q <= SEQ_RST;
        end else begin
            q <= d;
        end
    end

    assign bulk_enable_out = q.bulk_en;
    assign reset_ready_out = q.ready;
    assign server_reset_n_out = q.srv_run;
    assign os_shutdown_req_out = q.shut_req;
    assign led_green_out = q.led_green;
    assign led_amber_out = q.led_amber;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst);

    chk_soft_request: assert property (
        q.st == ST_ON && short_rel && os_running_in && !host_booting_in && !long_hit
        |=> os_shutdown_req_out && bulk_enable_out)
        else $error("short press with OS up did not request shutdown");

    chk_long_hard_off: assert property (
        long_hit && (q.st == ST_ON || q.st == ST_SOFT_OFF) |=> !bulk_enable_out && !server_reset_n_out)
        else $error("long press did not remove power");

    chk_boot_press_off: assert property (
        q.st == ST_ON && host_booting_in && press_start |=> !bulk_enable_out)
        else $error("press while booting did not power off");

    chk_hung_short_ignored: assert property (
        q.st == ST_ON && short_rel && !os_running_in && !host_booting_in
        |=> bulk_enable_out && !os_shutdown_req_out)
        else $error("short press with OS absent was not ignored");

    chk_mask_holds_off: assert property (
        $fell(bulk_enable_out) |-> !bulk_enable_out [*8])
        else $error("power came back inside the mask");

    chk_mask_length: assert property (
        q.st == ST_MASK && q.mask_cnt != CNT_W'(MASK_CYC - 1) |=> q.st == ST_MASK)
        else $error("mask ended early");

    chk_led_no_mains: assert property (
        !ac_present_in |=> !led_green_out && !led_amber_out)
        else $error("indicator lit without mains");

    chk_led_matches_power: assert property (
        ac_present_in |=> led_green_out == bulk_enable_out && led_amber_out != bulk_enable_out)
        else $error("indicator colour disagrees with power state");

    chk_hk_holds_reset: assert property (
        disable iff (srst_in) !housekeeping_ok_in |=> q.st == ST_STANDBY && !bulk_enable_out)
        else $error("sequencer active before housekeeping power");

    chk_press_powers_up: assert property (
        q.st == ST_STANDBY && press_start |=> bulk_enable_out && q.st == ST_POWER_UP)
        else $error("press from standby did not enable supplies");

    chk_ready_after_clocks: assert property (
        $rose(reset_ready_out) |-> $past(clocks_stable_in) && bulk_enable_out)
        else $error("ready raised without stable clocks");

    chk_release_after_ready: assert property (
        $rose(server_reset_n_out) |-> $past(reset_ready_out))
        else $error("server reset released before ready");

    chk_soft_to_standby: assert property (
        q.st == ST_SOFT_OFF && os_off_done_in && ac_present_in
        |=> q.st == ST_MASK && led_amber_out && !os_shutdown_req_out)
        else $error("graceful shutdown did not end in amber standby");

    cov_power_up: cover property (q.st == ST_READY ##1 q.st == ST_ON);
    cov_graceful: cover property (q.st == ST_SOFT_OFF ##1 q.st == ST_MASK);
    cov_hard: cover property (q.st == ST_ON && long_hit);
    cov_mask_done: cover property (q.st == ST_MASK ##1 q.st == ST_STANDBY && held);

endmodule : pbs_sequencer

// file: rtl/pbs_pkg.sv
// constants, timing figures and state codes for the power button sequencer
// assumes a single standby-domain clock at 10 MHz
package pbs_pkg;

    // clock rate and time units
    localparam longint unsigned CLK_HZ = 64'h989680;         // 10 MHz
    localparam longint unsigned MS_PER_S = 64'h3e8;          // 1000 ms per second
    localparam longint unsigned PRESS_LIMIT_MS = 64'hfa0;    // 4000 ms long-press threshold
    localparam longint unsigned MASK_MS = 64'hfa0;           // 4000 ms button mask after power-down
    localparam longint unsigned DEBOUNCE_MS = 64'h14;        // 20 ms contact settle time

    // cycle counts derived from the times above
    localparam int unsigned LONG_PRESS_CYC_DEF = 32'(CLK_HZ * PRESS_LIMIT_MS / MS_PER_S);
    localparam int unsigned MASK_CYC_DEF = 32'(CLK_HZ * MASK_MS / MS_PER_S);
    localparam int unsigned DEBOUNCE_CYC_DEF = 32'(CLK_HZ * DEBOUNCE_MS / MS_PER_S);

    // counter width, large enough for 40,000,000 cycles
    localparam int unsigned CNT_W = 26;

    // sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_STANDBY  = 6'h01,
        ST_POWER_UP = 6'h02,
        ST_READY    = 6'h04,
        ST_ON       = 6'h08,
        ST_SOFT_OFF = 6'h10,
        ST_MASK     = 6'h20
    } pbs_state_t;

endpackage : pbs_pkg

// file: rtl/pbs_press_timer.sv
// debounces the front-panel button and classifies presses as short or long
// assumes the button input is synchronous to sys_clk_in, high while pressed
`timescale 1ns/100ps
module pbs_press_timer import pbs_pkg::*; #(
    parameter int unsigned LONG_PRESS_CYC = LONG_PRESS_CYC_DEF,
    parameter int unsigned DEBOUNCE_CYC = DEBOUNCE_CYC_DEF
) (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic button_in,
    output logic press_start_out,
    output logic short_release_out,
    output logic long_hit_out,
    output logic held_out
);

    typedef struct packed {
        logic stable;
        logic [CNT_W-1:0] db_cnt;
        logic [CNT_W-1:0] press_cnt;
        logic long_done;
        logic p_start;
        logic s_rel;
        logic l_hit;
    } pbs_press_t;

    localparam pbs_press_t PRESS_RST = '0;

    pbs_press_t q;
    pbs_press_t d;
    logic long_now;

    // press length counter then debounce; a press of exactly the limit counts as long
    always_comb begin
        d = q;
        d.p_start = 1'b0;
        d.s_rel = 1'b0;
        d.l_hit = 1'b0;
        long_now = q.stable && !q.long_done && (q.press_cnt == CNT_W'(LONG_PRESS_CYC - 1));
        if (q.stable && !q.long_done) begin
            if (long_now) begin
                d.l_hit = 1'b1;
                d.long_done = 1'b1;
            end else begin
                d.press_cnt = q.press_cnt + 1'b1;
            end
        end
        // input must differ for a full settle time before the level is accepted
        if (button_in != q.stable) begin
            if (q.db_cnt == CNT_W'(DEBOUNCE_CYC - 1)) begin
                d.stable = button_in;
                d.db_cnt = '0;
                if (button_in) begin
                    d.p_start = 1'b1;
                    d.press_cnt = '0;
                    d.long_done = 1'b0;
                end else if (!q.long_done && !long_now) begin
                    d.s_rel = 1'b1;
                end
            end else begin
                d.db_cnt = q.db_cnt + 1'b1;
            end
        end else begin
            d.db_cnt = '0; // bounce restarts the settle time
        end
    end

    // state register
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            q <= PRESS_RST;
        end else begin
            q <= d;
        end
    end

    assign press_start_out = q.p_start;
    assign short_release_out = q.s_rel;
    assign long_hit_out = q.l_hit;
    assign held_out = q.stable;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);

    // the release may settle on the very edge that flags the long press, so look one back
    chk_long_at_limit: assert property (
        long_hit_out |-> $past(held_out) && $past(q.press_cnt) == CNT_W'(LONG_PRESS_CYC - 1))
        else $error("long press not flagged at the limit");

    chk_no_both_kinds: assert property (
        long_hit_out |-> !short_release_out ##1 !short_release_out)
        else $error("press reported as short and long");

endmodule : pbs_press_timer

// file: testbench/pbs_host_model.sv
// far-side model: bulk supplies, clock generator, host firmware and os
// assumes the sequencer outputs are registered on sys_clk_in
`timescale 1ns/100ps
module pbs_host_model (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic bulk_enable_in,
    input wire logic server_reset_n_in,
    input wire logic os_shutdown_req_in,
    input wire logic [1:0] mode_in,
    input wire logic [3:0] delay_in,
    output logic clocks_stable_out,
    output logic host_booting_out,
    output logic os_running_out,
    output logic os_off_done_out
);
    logic [7:0] pwr_q;
    logic [7:0] run_q;
    logic [7:0] req_q;
    logic [7:0] dly;

    assign dly = {4'h0, delay_in};

    // counters restart when power drops, so nothing stale survives an off
    always_ff @(posedge sys_clk_in) begin
        if (srst_in || !bulk_enable_in) begin
            pwr_q <= 8'h00;
            run_q <= 8'h00;
            req_q <= 8'h00;
        end else begin
            if (pwr_q != 8'hff) pwr_q <= pwr_q + 8'h01;
            if (!server_reset_n_in) run_q <= 8'h00;
            else if (run_q != 8'hff) run_q <= run_q + 8'h01;
            if (!os_shutdown_req_in) req_q <= 8'h00;
            else if (req_q != 8'hff) req_q <= req_q + 8'h01;
        end
    end

    // mode 0: os comes up, 1: os hung after handoff, 2: stuck before handoff
    assign clocks_stable_out = bulk_enable_in && pwr_q >= dly;
    assign host_booting_out = server_reset_n_in && (mode_in == 2'h2 || run_q < dly);
    assign os_running_out = server_reset_n_in && mode_in == 2'h0 && run_q >= dly;
    assign os_off_done_out = os_shutdown_req_in && req_q >= dly;
endmodule : pbs_host_model

// file: testbench/tb.sv
// self-checking bench for the power button sequencer
// assumes shortened counts: long 40, mask 30, debounce 3 cycles
`timescale 1ns/100ps
module tb;
    localparam int unsigned LONG = 40;
    // output vector {bulk, ready, reset_n, req, green, amber}
    localparam logic [5:0] DARK = 6'h00;
    localparam logic [5:0] AMB = 6'h01;
    localparam logic [5:0] UP = 6'h22;
    localparam logic [5:0] RDY = 6'h32;
    localparam logic [5:0] ON = 6'h3a;
    localparam logic [5:0] REQ = 6'h3e;

    logic sys_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic hk_ok = 1'b1;
    logic ac = 1'b1;
    logic button = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [3:0] dly = 4'h4;
    logic stable, booting, running, off_done;
    logic bulk, ready, rst_n, req, green, amber;
    logic [5:0] vec;
    logic [5:0] prev = 6'h00;
    logic [5:0] exp_q[$];
    int seed = 22;
    int fail_count = 0;
    int checked = 0;

    assign vec = {bulk, ready, rst_n, req, green, amber};

    always #50 sys_clk_in = ~sys_clk_in;

    pbs_sequencer #(.LONG_PRESS_CYC(LONG), .MASK_CYC(30), .DEBOUNCE_CYC(3)) i_dut (
        .sys_clk_in(sys_clk_in), .srst_in(srst_in), .housekeeping_ok_in(hk_ok),
        .ac_present_in(ac), .button_in(button), .host_booting_in(booting),
        .os_running_in(running), .os_off_done_in(off_done), .clocks_stable_in(stable),
        .bulk_enable_out(bulk), .reset_ready_out(ready), .server_reset_n_out(rst_n),
        .os_shutdown_req_out(req), .led_green_out(green), .led_amber_out(amber));

    pbs_host_model i_host (
        .sys_clk_in(sys_clk_in), .srst_in(srst_in), .bulk_enable_in(bulk),
        .server_reset_n_in(rst_n), .os_shutdown_req_in(req), .mode_in(mode),
        .delay_in(dly), .clocks_stable_out(stable), .host_booting_out(booting),
        .os_running_out(running), .os_off_done_out(off_done));

    // watcher: every output change consumes the oldest note
    always @(negedge sys_clk_in) begin
        if (srst_in) prev = vec;
        else if (vec !== prev) begin
            checked++;
            if (exp_q.size() == 0) begin
                fail_count++;
                $display("BAD %0t unexpected outputs %h", $time, vec);
            end else begin
                if (vec !== exp_q[0]) begin
                    fail_count++;
                    $display("BAD %0t outputs %h expected %h", $time, vec, exp_q[0]);
                end
                void'(exp_q.pop_front());
            end
            prev = vec;
        end
    end

    task close_out;
        $display("counts: checked %0d, failed %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out

    // a short bounce first, which the debounce must swallow
    task press(input int n);
        int g;
        g = 1 + ({$random(seed)} % 2);
        button <= 1'b1;
        repeat (g) @(posedge sys_clk_in);
        button <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        button <= 1'b1;
        repeat (n) @(posedge sys_clk_in);
        button <= 1'b0;
        repeat (5) @(posedge sys_clk_in);
    endtask : press

    // bounded wait until all notes are consumed, then room for strays
    task settle(input string name);
        int i;
        for (i = 0; i < 400 && exp_q.size() > 0; i++) @(posedge sys_clk_in);
        if (exp_q.size() > 0) begin
            fail_count++;
            $display("BAD %0t timeout in %s", $time, name);
            close_out();
        end
        repeat (10) @(posedge sys_clk_in);
        $display("test %s done", name);
    endtask : settle

    // short press keeps the release ahead of the on state
    task power_up(input logic [1:0] m);
        mode <= m;
        dly <= 4'h4 + 4'({$random(seed)} % 12);
        exp_q.push_back(UP);
        exp_q.push_back(RDY);
        exp_q.push_back(ON);
        press(4);
        settle("power up");
        repeat (40) @(posedge sys_clk_in);
    endtask : power_up

    initial begin
        exp_q.push_back(AMB);
        repeat (4) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        settle("reset");
        power_up(2'h0);
        exp_q.push_back(REQ);
        exp_q.push_back(AMB);
        press(10);
        settle("graceful");
        press(10);
        settle("mask");
        repeat (30) @(posedge sys_clk_in);
        power_up(2'h1);
        press(LONG - 1);
        settle("hung short");
        exp_q.push_back(AMB);
        press(LONG);
        settle("hung long");
        repeat (40) @(posedge sys_clk_in);
        power_up(2'h0);
        exp_q.push_back(AMB);
        press(60);
        settle("hard");
        repeat (40) @(posedge sys_clk_in);
        power_up(2'h2);
        exp_q.push_back(AMB);
        press(10);
        settle("booting");
        repeat (40) @(posedge sys_clk_in);
        exp_q.push_back(DARK);
        exp_q.push_back(AMB);
        hk_ok <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        hk_ok <= 1'b1;
        settle("housekeeping");
        exp_q.push_back(DARK);
        ac <= 1'b0;
        settle("no mains");
        close_out();
    end
endmodule : tb
